/* File: src/scp_sys_ctl.sv */
`timescale 1ns/1ps

module scp_sys_ctl
    import scp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic parity_err_in,
    input wire logic chan_check_in,
    input wire logic chan_timeout_in,
    input wire logic watchdog_to_in,
    input wire logic timer2_out_in,
    input wire logic refresh_req_in,
    output logic [7:0] io_rdata_out,
    output logic nmi_out,
    output logic arb_halt_out,
    output logic tick_interrupt_request_clear_out,
    output logic speaker_data_en_out,
    output logic timer2_gate_out,
    output logic disk_lamp_out,
    output logic address_bit_twenty_gate_out,
    output logic alt_reset_out,
    output logic cpu_reset_out,
    output logic password_locked_out
);

    // ==========================================================
    // decode
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] port);
        hit = (addr == port);
    endfunction : hit

    function automatic logic in_pwd(input logic [6:0] idx);
        in_pwd = (idx >= PWD_BASE) && (idx < PWD_BASE + 7'(PWD_BYTES));
    endfunction : in_pwd

    logic wr_b;
    logic wr_a;
    logic wr_arb;
    logic wr_idx;
    logic wr_data;
    logic rd_data;

    always_comb begin
        wr_b = 1'b0;
        wr_a = 1'b0;
        wr_arb = 1'b0;
        wr_idx = 1'b0;
        wr_data = 1'b0;
        if (io_wr_in && hit(io_addr_in, PORT_B_ADDR)) begin
            wr_b = 1'b1;
        end else if (io_wr_in && hit(io_addr_in, PORT_A_ADDR)) begin
            wr_a = 1'b1;
        end else if (io_wr_in && hit(io_addr_in, ARB_ADDR)) begin
            wr_arb = 1'b1;
        end else if (io_wr_in && hit(io_addr_in, CRAM_IDX_ADDR)) begin
            wr_idx = 1'b1;
        end else if (io_wr_in && hit(io_addr_in, CRAM_DATA_ADDR)) begin
            wr_data = 1'b1;
        end
    end

    assign rd_data = io_rd_in && hit(io_addr_in, CRAM_DATA_ADDR);

    // ==========================================================
    // clock ram index and nmi mask
    logic nmi_mask_ff;
    logic [6:0] cram_idx_ff;

    always_ff @(posedge clk_in) begin
        if (por_in) begin
            nmi_mask_ff <= NMI_MASK_RST;
        end else if (wr_idx) begin
            nmi_mask_ff <= io_wdata_in[IDX_MASK_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            cram_idx_ff <= '0;
        end else if (wr_idx) begin
            cram_idx_ff <= io_wdata_in[6:0];
        end
    end

    // ==========================================================
    // port b control bits
    logic chk_en_n_ff;
    logic par_en_n_ff;
    logic spk_en_ff;
    logic t2_gate_ff;
    logic tick_clr_ff;

    always_ff @(posedge clk_in) begin
        if (por_in) begin
            chk_en_n_ff <= CHECK_EN_N_RST;
            par_en_n_ff <= CHECK_EN_N_RST;
        end else if (wr_b) begin
            chk_en_n_ff <= io_wdata_in[PB_CHK_EN_N];
            par_en_n_ff <= io_wdata_in[PB_PAR_EN_N];
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            spk_en_ff <= 1'b0;
            t2_gate_ff <= 1'b0;
        end else if (wr_b) begin
            spk_en_ff <= io_wdata_in[PB_SPK_EN];
            t2_gate_ff <= io_wdata_in[PB_T2_GATE];
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            tick_clr_ff <= 1'b0;
        end else begin
            tick_clr_ff <= wr_b && io_wdata_in[PB_TICK_CLR];
        end
    end

    // ==========================================================
    // check latches, refresh toggle, watchdog status
    logic par_latch_ff;
    logic chk_latch_ff;
    logic refresh_ff;
    logic wdog_ff;

    // a disabled check holds its latch clear; an event sets it only while enabled
    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            par_latch_ff <= 1'b0;
            chk_latch_ff <= 1'b0;
        end else begin
            if (parity_err_in && !par_en_n_ff) begin
                par_latch_ff <= 1'b1;
            end else if (par_en_n_ff) begin
                par_latch_ff <= 1'b0;
            end
            if (chan_check_in && !chk_en_n_ff) begin
                chk_latch_ff <= 1'b1;
            end else if (chk_en_n_ff) begin
                chk_latch_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            refresh_ff <= 1'b0;
        end else if (refresh_req_in) begin
            refresh_ff <= !refresh_ff;
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            wdog_ff <= 1'b0;
        end else if (watchdog_to_in) begin
            wdog_ff <= 1'b1;
        end
    end

    // ==========================================================
    // nmi and arbitration halt
    logic nmi_ff;
    logic nmi_event;

    assign nmi_event = ((par_latch_ff || chk_latch_ff) && !nmi_mask_ff)
        || chan_timeout_in || watchdog_to_in;

    always_ff @(posedge clk_in) begin
        if (rst_in || por_in) begin
            nmi_ff <= 1'b0;
        end else if (nmi_event) begin
            nmi_ff <= 1'b1;
        end else if (wr_arb && !io_wdata_in[ARB_NMI_BIT]) begin
            nmi_ff <= 1'b0;
        end
    end

    // ==========================================================
    // port a
    logic [1:0] lamp_ff;
    logic lock_ff;
    logic a20_ff;
    logic alt_bit_ff;
    logic alt_start_ff;

    always_ff @(posedge clk_in) begin
        if (por_in) begin
            lamp_ff <= LAMP_RST;
        end else if (wr_a) begin
            lamp_ff <= io_wdata_in[PA_LAMP_HI:PA_LAMP_LO];
        end
    end

    // only a power-up clears the lock
    always_ff @(posedge clk_in) begin
        if (por_in) begin
            lock_ff <= 1'b0;
        end else if (wr_a && io_wdata_in[PA_LOCK]) begin
            lock_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            a20_ff <= A20_RST;
        end else if (wr_a) begin
            a20_ff <= io_wdata_in[PA_A20];
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            alt_bit_ff <= ALT_RST;
            alt_start_ff <= 1'b0;
        end else begin
            alt_start_ff <= wr_a && io_wdata_in[PA_ALT_RST] && !alt_bit_ff;
            if (wr_a) begin
                alt_bit_ff <= io_wdata_in[PA_ALT_RST];
            end
        end
    end

    // ==========================================================
    // alternate reset sequencer
    scp_alt_if alt_link ();

    assign alt_link.start = alt_start_ff;

    scp_alt_reset u_alt_reset (
        .clk_in(clk_in),
        .rst_in(rst_in || por_in),
        .alt(alt_link.seq)
    );

    // ==========================================================
    // password area
    logic [7:0] pwd_mem [PWD_BYTES];
    logic [2:0] pwd_sel;

    assign pwd_sel = 3'(cram_idx_ff - PWD_BASE);

    always_ff @(posedge clk_in) begin
        if (por_in) begin
            for (int i = 0; i < PWD_BYTES; i++) begin
                pwd_mem[i] <= PWD_RST;
            end
        end else if (wr_data && in_pwd(cram_idx_ff) && !lock_ff) begin
            pwd_mem[pwd_sel] <= io_wdata_in;
        end
    end

    // ==========================================================
    // read data
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = RD_ZERO;
        if (io_rd_in && hit(io_addr_in, PORT_B_ADDR)) begin
            nxt_rdata[PB_PAR_LATCH] = par_latch_ff;
            nxt_rdata[PB_CHK_LATCH] = chk_latch_ff;
            nxt_rdata[PB_T2_OUT] = timer2_out_in;
            nxt_rdata[PB_REFRESH] = refresh_ff;
            nxt_rdata[PB_CHK_EN_N] = chk_en_n_ff;
            nxt_rdata[PB_PAR_EN_N] = par_en_n_ff;
            nxt_rdata[PB_SPK_EN] = spk_en_ff;
            nxt_rdata[PB_T2_GATE] = t2_gate_ff;
        end else if (io_rd_in && hit(io_addr_in, PORT_A_ADDR)) begin
            nxt_rdata[PA_LAMP_HI:PA_LAMP_LO] = lamp_ff;
            nxt_rdata[PA_WDOG] = wdog_ff;
            nxt_rdata[PA_LOCK] = lock_ff;
            nxt_rdata[PA_A20] = a20_ff;
            nxt_rdata[PA_ALT_RST] = alt_bit_ff;
        end else if (rd_data && in_pwd(cram_idx_ff) && !lock_ff) begin
            nxt_rdata = pwd_mem[pwd_sel];
        end
    end

    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            io_rdata_out <= RD_ZERO;
        end else begin
            io_rdata_out <= nxt_rdata;
        end
    end

    // ==========================================================
    // output registers
    always_ff @(posedge clk_in) begin
        if (por_in || rst_in) begin
            nmi_out <= 1'b0;
            arb_halt_out <= 1'b0;
            tick_interrupt_request_clear_out <= 1'b0;
            speaker_data_en_out <= 1'b0;
            timer2_gate_out <= 1'b0;
            disk_lamp_out <= 1'b0;
            address_bit_twenty_gate_out <= A20_RST;
            alt_reset_out <= 1'b0;
            cpu_reset_out <= 1'b0;
            password_locked_out <= 1'b0;
        end else begin
            nmi_out <= nmi_ff;
            arb_halt_out <= nmi_ff;
            tick_interrupt_request_clear_out <= tick_clr_ff;
            speaker_data_en_out <= spk_en_ff;
            timer2_gate_out <= t2_gate_ff;
            disk_lamp_out <= |lamp_ff;
            address_bit_twenty_gate_out <= a20_ff;
            alt_reset_out <= alt_link.alt_pulse;
            cpu_reset_out <= alt_link.cpu_reset;
            password_locked_out <= lock_ff;
        end
    end

    // ==========================================================
    // checks
    chk_nmi_raise_watchdog: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        watchdog_to_in |=> nmi_ff ##1 nmi_out)
        else $error("watchdog timeout did not raise nmi");

    chk_arb_halt_hold: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        (nmi_ff && !(wr_arb && !io_wdata_in[ARB_NMI_BIT])) |=> nmi_ff)
        else $error("arbitration halt dropped without clear");

    chk_nmi_sys_reset: assert property (@(posedge clk_in)
        rst_in |=> !nmi_ff)
        else $error("system reset left nmi pending");

    chk_mask_blocks_checks: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        (nmi_mask_ff && !nmi_ff && !chan_timeout_in && !watchdog_to_in) |=> !nmi_ff)
        else $error("masked source raised nmi");

    chk_tick_clear_pulse: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        (wr_b && io_wdata_in[PB_TICK_CLR]) |=> ##1 tick_interrupt_request_clear_out)
        else $error("tick latch clear not issued");

    chk_refresh_toggle: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        refresh_req_in |=> (refresh_ff != $past(refresh_ff)))
        else $error("refresh bit did not toggle");

    chk_lock_sticky: assert property (@(posedge clk_in) disable iff (por_in)
        lock_ff |=> lock_ff)
        else $error("security lock cleared without power cycle");

    chk_alt_bit_latched: assert property (@(posedge clk_in) disable iff (rst_in || por_in)
        (alt_link.busy && !wr_a) |=> alt_bit_ff == $past(alt_bit_ff))
        else $error("alternate reset bit changed during sequence");

endmodule : scp_sys_ctl

/* File: src/scp_pkg.sv */
package scp_pkg;

    // ==========================================================
    // i/o port addresses
    localparam logic [15:0] PORT_B_ADDR = 16'h0061;
    localparam logic [15:0] PORT_A_ADDR = 16'h0092;
    localparam logic [15:0] ARB_ADDR = 16'h0090;
    localparam logic [15:0] CRAM_IDX_ADDR = 16'h0070;
    localparam logic [15:0] CRAM_DATA_ADDR = 16'h0071;

    // ==========================================================
    // port b bit positions
    localparam int unsigned PB_TICK_CLR = 7;
    localparam int unsigned PB_PAR_LATCH = 7;
    localparam int unsigned PB_CHK_LATCH = 6;
    localparam int unsigned PB_T2_OUT = 5;
    localparam int unsigned PB_REFRESH = 4;
    localparam int unsigned PB_CHK_EN_N = 3;
    localparam int unsigned PB_PAR_EN_N = 2;
    localparam int unsigned PB_SPK_EN = 1;
    localparam int unsigned PB_T2_GATE = 0;

    // ==========================================================
    // port a bit positions
    localparam int unsigned PA_LAMP_HI = 7;
    localparam int unsigned PA_LAMP_LO = 6;
    localparam int unsigned PA_WDOG = 4;
    localparam int unsigned PA_LOCK = 3;
    localparam int unsigned PA_A20 = 1;
    localparam int unsigned PA_ALT_RST = 0;

    // ==========================================================
    // other bit positions
    localparam int unsigned ARB_NMI_BIT = 6;
    localparam int unsigned IDX_MASK_BIT = 7;

    // ==========================================================
    // reset values
    localparam logic NMI_MASK_RST = 1'b1;
    localparam logic CHECK_EN_N_RST = 1'b1;
    localparam logic [1:0] LAMP_RST = 2'h0;
    localparam logic A20_RST = 1'b0;
    localparam logic ALT_RST = 1'b0;
    localparam logic [7:0] PWD_RST = 8'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // ==========================================================
    // password area of the clock ram index space
    localparam logic [6:0] PWD_BASE = 7'h38;
    localparam int unsigned PWD_BYTES = 8;

    // ==========================================================
    // timing
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned ALT_PULSE_MIN_NS = 100;
    localparam int unsigned ALT_PULSE_MAX_NS = 125;
    localparam int unsigned CPU_RST_DELAY_NS = 6720;
    localparam int unsigned ALT_SEQ_NS = 13400;
    localparam int unsigned ALT_PULSE_CYC = (ALT_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CPU_RST_DELAY_CYC = (CPU_RST_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ALT_SEQ_CYC = ALT_SEQ_NS / CLK_NS;
    localparam int unsigned SEQ_CNT_W = 11;

    // ==========================================================
    // alternate reset sequencer states
    typedef enum logic [1:0] {
        SCP_IDLE = 2'b00,
        SCP_PULSE = 2'b01,
        SCP_WAIT = 2'b10,
        SCP_HOLD = 2'b11
    } scp_seq_t;

endpackage : scp_pkg

/* File: src/scp_alt_if.sv */
`timescale 1ns/1ps

// ==========================================================
// link between port logic and alternate reset sequencer
interface scp_alt_if;
    logic start;
    logic busy;
    logic alt_pulse;
    logic cpu_reset;

    modport ctl (output start, input busy, input alt_pulse, input cpu_reset);
    modport seq (input start, output busy, output alt_pulse, output cpu_reset);
endinterface : scp_alt_if

/* File: src/scp_alt_reset.sv */
`timescale 1ns/1ps

module scp_alt_reset
    import scp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    scp_alt_if.seq alt
);

    // ==========================================================
    // sequencer
    scp_seq_t state_ff;
    scp_seq_t nxt_state;
    logic [SEQ_CNT_W-1:0] cnt_ff;
    logic pulse_ff;
    logic cpu_rst_ff;
    logic busy_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCP_IDLE: begin
                if (alt.start) begin
                    nxt_state = SCP_PULSE;
                end
            end
            SCP_PULSE: begin
                if (cnt_ff == SEQ_CNT_W'(ALT_PULSE_CYC - 1)) begin
                    nxt_state = SCP_WAIT;
                end
            end
            SCP_WAIT: begin
                if (cnt_ff == SEQ_CNT_W'(CPU_RST_DELAY_CYC - 1)) begin
                    nxt_state = SCP_HOLD;
                end
            end
            SCP_HOLD: begin
                if (cnt_ff == SEQ_CNT_W'(ALT_SEQ_CYC - 1)) begin
                    nxt_state = SCP_IDLE;
                end
            end
            default: nxt_state = SCP_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= SCP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || nxt_state == SCP_IDLE || state_ff == SCP_IDLE) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + SEQ_CNT_W'(1);
        end
    end

    // pulse then delayed processor reset, all inside the sequence time
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pulse_ff <= 1'b0;
            cpu_rst_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            pulse_ff <= (nxt_state == SCP_PULSE);
            cpu_rst_ff <= (nxt_state == SCP_HOLD);
            busy_ff <= (nxt_state != SCP_IDLE);
        end
    end

    // length of the current pulse, for the width check
    logic [3:0] pulse_len_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in || !pulse_ff) begin
            pulse_len_ff <= '0;
        end else begin
            pulse_len_ff <= pulse_len_ff + 4'h1;
        end
    end

    assign alt.alt_pulse = pulse_ff;
    assign alt.cpu_reset = cpu_rst_ff;
    assign alt.busy = busy_ff;

    // ==========================================================
    // checks
    chk_alt_pulse_start: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == SCP_IDLE && alt.start) |=> pulse_ff)
        else $error("alternate reset pulse did not start");

    chk_alt_pulse_width: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(pulse_ff) |-> pulse_len_ff == 4'(ALT_PULSE_CYC))
        else $error("alternate reset pulse width wrong");

    chk_alt_pulse_max: assert property (@(posedge clk_in) disable iff (rst_in)
        pulse_len_ff <= 4'(ALT_PULSE_CYC))
        else $error("alternate reset pulse too long");

    chk_cpu_reset_delay: assert property (@(posedge clk_in) disable iff (rst_in)
        (cpu_rst_ff && state_ff == SCP_HOLD) |-> cnt_ff >= SEQ_CNT_W'(CPU_RST_DELAY_CYC - 1))
        else $error("processor reset came too early");

    chk_seq_bound: assert property (@(posedge clk_in) disable iff (rst_in)
        cnt_ff <= SEQ_CNT_W'(ALT_SEQ_CYC - 1))
        else $error("alternate reset sequence ran too long");

endmodule : scp_alt_reset

/* File: bench/scp_cpu_model.sv */
`timescale 1ns/1ps

// ==========================================================
// processor side of the i/o port bus
module scp_cpu_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [15:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    bit slow;

    initial begin
        addr_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
        slow = 1'b0;
    end

    // one strobe cycle; released lines show the inverse, not the old value
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        repeat (slow ? 3 : 1) @(posedge clk_in);
        #1;
        addr_out = addr;
        wdata_out = data;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~addr;
        wdata_out = ~data;
    endtask : io_write

    task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
        repeat (slow ? 3 : 1) @(posedge clk_in);
        #1;
        addr_out = addr;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        data = rdata_in;
        rd_out = 1'b0;
        addr_out = ~addr;
    endtask : io_read
endmodule : scp_cpu_model

/* File: bench/tb.sv */
`timescale 1ns/1ps

// ==========================================================
// testbench
module tb;
    import scp_pkg::*;
    logic clk_in, rst_in, por_in, t2_in, refr_in, nmi, arb, tick, spk, gate, lamp, a20, alt;
    logic cpu_rst, locked, wr, rd;
    logic [3:0] ev;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [7:0] lv [4];
    int n_mismatch, checked, t;

    scp_cpu_model i_cpu (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));

    scp_sys_ctl i_dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .io_addr_in(addr),
        .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .parity_err_in(ev[0]),
        .chan_check_in(ev[1]), .chan_timeout_in(ev[2]), .watchdog_to_in(ev[3]),
        .timer2_out_in(t2_in), .refresh_req_in(refr_in), .io_rdata_out(rdata), .nmi_out(nmi),
        .arb_halt_out(arb), .tick_interrupt_request_clear_out(tick), .speaker_data_en_out(spk),
        .timer2_gate_out(gate), .disk_lamp_out(lamp), .address_bit_twenty_gate_out(a20),
        .alt_reset_out(alt), .cpu_reset_out(cpu_rst), .password_locked_out(locked));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ==========================================================
    // helpers
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check_val

    task automatic chk1(input logic seen, input logic exp);
        check_val({7'h00, seen}, {7'h00, exp});
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_cpu.io_read(a, v);
        check_val(v, exp);
    endtask : rd_chk

    task automatic fire(input int k);
        ev[k] = 1'b1;
        cyc(1);
        ev = 4'h0;
        cyc(3);
    endtask : fire

    // ==========================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        checked = 0;
        por_in = 1'b1;
        rst_in = 1'b1;
        ev = 4'h0;
        t2_in = 1'b0;
        refr_in = 1'b0;
        lv = '{8'h40, 8'h80, 8'hC0, 8'h00};
        cyc(10);
        por_in = 1'b0;
        rst_in = 1'b0;
        rd_chk(PORT_B_ADDR, 8'h0C);
        rd_chk(PORT_A_ADDR, 8'h00);
        // checks enabled but mask still at its power-up value
        i_cpu.io_write(PORT_B_ADDR, 8'h00);
        fire(0);
        chk1(nmi, 1'b0);
        i_cpu.io_write(PORT_B_ADDR, 8'h0C);
        i_cpu.io_write(CRAM_IDX_ADDR, 8'hB8);
        rd_chk(CRAM_DATA_ADDR, 8'h00);
        i_cpu.io_write(CRAM_DATA_ADDR, 8'h5A);
        rd_chk(CRAM_DATA_ADDR, 8'h5A);
        rd_chk(16'h0065, 8'h00);
        i_cpu.io_write(PORT_B_ADDR, 8'hF3);
        cyc(1);
        chk1(tick, 1'b1);
        chk1(spk, 1'b1);
        chk1(gate, 1'b1);
        cyc(1);
        chk1(tick, 1'b0);
        rd_chk(PORT_B_ADDR, 8'h03);
        t2_in = 1'b1;
        for (int i = 0; i < 2; i++) begin
            refr_in = 1'b1;
            cyc(1);
            refr_in = 1'b0;
            cyc(2);
            rd_chk(PORT_B_ADDR, i == 0 ? 8'h33 : 8'h23);
        end
        // unmasked checks, then cleared through the arbitration port
        i_cpu.io_write(CRAM_IDX_ADDR, 8'h38);
        rd_chk(CRAM_DATA_ADDR, 8'h5A);
        for (int k = 0; k < 2; k++) begin
            fire(k);
            chk1(nmi, 1'b1);
            chk1(arb, 1'b1);
            rd_chk(PORT_B_ADDR, k == 0 ? 8'hA3 : 8'h63);
            i_cpu.io_write(PORT_B_ADDR, 8'h0F);
            i_cpu.io_write(ARB_ADDR, 8'h00);
            cyc(3);
            chk1(arb, 1'b0);
            i_cpu.io_write(PORT_B_ADDR, 8'h03);
        end
        // masked: parity held off, time-out passes
        i_cpu.io_write(CRAM_IDX_ADDR, 8'hB8);
        rd_chk(CRAM_DATA_ADDR, 8'h5A);
        fire(0);
        chk1(nmi, 1'b0);
        rd_chk(PORT_B_ADDR, 8'hA3);
        i_cpu.io_write(PORT_B_ADDR, 8'h0F);
        fire(2);
        chk1(nmi, 1'b1);
        i_cpu.io_write(ARB_ADDR, 8'h00);
        cyc(3);
        chk1(nmi, 1'b0);
        i_cpu.slow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            i_cpu.io_write(PORT_A_ADDR, lv[i]);
            cyc(2);
            chk1(lamp, lv[i] != 8'h00);
            rd_chk(PORT_A_ADDR, lv[i]);
        end
        i_cpu.io_write(PORT_A_ADDR, 8'h26);
        cyc(2);
        chk1(a20, 1'b1);
        rd_chk(PORT_A_ADDR, 8'h02);
        i_cpu.io_write(PORT_A_ADDR, 8'h03);
        t = 0;
        while (alt !== 1'b1 && t < 20) begin
            cyc(1);
            t++;
        end
        t = 0;
        while (alt === 1'b1 && t < 20) begin
            cyc(1);
            t++;
        end
        chk1(t >= 10 && t <= 12, 1'b1);
        while (cpu_rst !== 1'b1 && t < 1400) begin
            cyc(1);
            t++;
        end
        chk1(t >= 672, 1'b1);
        while (cpu_rst === 1'b1 && t < 1400) begin
            cyc(1);
            t++;
        end
        chk1(t <= 1340, 1'b1);
        rd_chk(PORT_A_ADDR, 8'h03);
        i_cpu.io_write(PORT_A_ADDR, 8'h0A);
        rd_chk(PORT_A_ADDR, 8'h0A);
        chk1(locked, 1'b1);
        i_cpu.io_write(PORT_A_ADDR, 8'h0B);
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        rd_chk(PORT_A_ADDR, 8'h08);
        chk1(a20, 1'b0);
        i_cpu.io_write(PORT_A_ADDR, 8'h00);
        rd_chk(PORT_A_ADDR, 8'h08);
        i_cpu.io_write(CRAM_IDX_ADDR, 8'hB8);
        rd_chk(CRAM_DATA_ADDR, 8'h00);
        fire(3);
        chk1(nmi, 1'b1);
        rd_chk(PORT_A_ADDR, 8'h18);
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        cyc(1);
        chk1(nmi, 1'b0);
        complete_run();
    end
endmodule : tb
